// ### logic/tape_read_monitor.sv
// Read-side tape monitor: byte ends, record and file marks, file gaps,
// cartridge removal latch and marker debounce, with a small register port.
// Assumes all pins but the processor port are asynchronous to CLK; the processor port is on CLK.
`timescale 1ns/10ps
module tape_read_monitor
   import tape_mon_pkg::*;
#(
   parameter logic [12:0] GAP_CYC  = tape_mon_pkg::GAP_CYCLES,
   parameter logic [21:0] FILE_CYC = tape_mon_pkg::FILE_CYCLES
)
(
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic       SYS_RESET_PULSE,
   input  wire logic       LOAD_SWITCH,
   input  wire logic       CART_ACK,
   input  wire logic       FIND_GAP_ENABLE,
   input  wire logic       FILE_FIND_ENABLE,
   input  wire logic       TAPE_RD_CLK,
   input  wire logic       TAPE_RD_DATA,
   input  wire logic       TAPE_BEGIN_MARKER,
   input  wire logic       TAPE_END_MARKER,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   output logic            IRQ,
   output logic            CARTRIDGE_MISSING,
   output logic            LOAD_INIT,
   output logic            BEGIN_DET,
   output logic            END_DET,
   output logic            RECORD_MARK_DET,
   output logic            FILE_MARK_DET,
   output logic            BYTE_READY,
   output logic            FILE_GAP_FOUND,
   output logic      [7:0] READ_BYTE
);
   import tape_mon_pkg::*;

   typedef struct packed {
      logic        rc_s1;
      logic        rc_s2;
      logic        rc_prev;
      logic        rd_s1;
      logic        rd_s2;
      logic        ls_s1;
      logic        ls_s2;
      logic        ack_s1;
      logic        ack_s2;
      logic        ack_prev;
      logic        fge_s1;
      logic        fge_s2;
      logic        ffe_s1;
      logic        ffe_s2;
      logic        rp_s1;
      logic        rp_s2;
      logic [1:0]  mk_s1;
      logic [1:0]  mk_s2;
      logic [12:0] gap_cnt;
      logic        gap_on;
      logic [3:0]  mark_cnt;
      logic [3:0]  bit_cnt;
      logic [21:0] file_cnt;
      logic        file_arm;
      logic        file_found;
      logic [7:0]  shreg;
      logic        missing;
      logic        load;
      logic [1:0]  clean_prev;
      logic [6:0]  status;
      logic [6:0]  mask;
      logic [7:0]  rdata;
      logic        irq;
   } mon_state_t;

   mon_state_t st_ff;
   mon_state_t nxt_st;
   logic       rd_pulse;
   logic       gap_exp;
   logic       bit_four;
   logic       lsb_tog;
   logic       ack_edge;
   logic [6:0] ev;

   marker_if mk ();

   ////////////////////////////////////////////////////////////////////////////
   // Marker debouncer
   marker_debounce u_deb (
      .CLK   (CLK),
      .RST_N (RST_N),
      .m     (mk.deb)
   );

   assign mk.raw = st_ff.mk_s2;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      nxt_st   = st_ff;
      gap_exp  = 1'b0;
      // Pin synchronisers: first stage feeds only the second
      nxt_st.rc_s1  = TAPE_RD_CLK;
      nxt_st.rc_s2  = st_ff.rc_s1;
      nxt_st.rd_s1  = TAPE_RD_DATA;
      nxt_st.rd_s2  = st_ff.rd_s1;
      nxt_st.ls_s1  = LOAD_SWITCH;
      nxt_st.ls_s2  = st_ff.ls_s1;
      nxt_st.ack_s1 = CART_ACK;
      nxt_st.ack_s2 = st_ff.ack_s1;
      nxt_st.fge_s1 = FIND_GAP_ENABLE;
      nxt_st.fge_s2 = st_ff.fge_s1;
      nxt_st.ffe_s1 = FILE_FIND_ENABLE;
      nxt_st.ffe_s2 = st_ff.ffe_s1;
      nxt_st.rp_s1  = SYS_RESET_PULSE;
      nxt_st.rp_s2  = st_ff.rp_s1;
      nxt_st.mk_s1  = {TAPE_END_MARKER, TAPE_BEGIN_MARKER};
      nxt_st.mk_s2  = st_ff.mk_s1;

      rd_pulse        = st_ff.rc_s2 & ~st_ff.rc_prev;
      nxt_st.rc_prev  = st_ff.rc_s2;

      if (rd_pulse && st_ff.fge_s2) begin
         nxt_st.gap_cnt = GAP_CYC;
         nxt_st.gap_on  = 1'b1;
      end else if (st_ff.gap_on) begin
         if (st_ff.gap_cnt <= 13'h0001) begin
            nxt_st.gap_on = 1'b0;
            gap_exp       = 1'b1;
         end else begin
            nxt_st.gap_cnt = st_ff.gap_cnt - 13'h0001;
         end
      end

      if (gap_exp) begin
         nxt_st.bit_cnt = 4'h0;
      end else if (rd_pulse && (st_ff.gap_on || st_ff.fge_s2)) begin
         nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
      end
      bit_four = (st_ff.bit_cnt == 4'h3) && (nxt_st.bit_cnt == 4'h4);

      if (rd_pulse) begin
         nxt_st.shreg = {st_ff.shreg[6:0], st_ff.rd_s2};
      end

      if (!st_ff.fge_s2 || bit_four) begin
         nxt_st.mark_cnt = 4'h0;
      end else if (gap_exp && !st_ff.mark_cnt[3]) begin
         nxt_st.mark_cnt = st_ff.mark_cnt + 4'h1;
      end

      lsb_tog = nxt_st.bit_cnt[0] ^ st_ff.bit_cnt[0];
      if (!st_ff.ffe_s2) begin
         nxt_st.file_cnt   = 22'h000000;
         nxt_st.file_arm   = 1'b0;
         nxt_st.file_found = 1'b0;
      end else if (lsb_tog) begin
         nxt_st.file_cnt   = FILE_CYC;
         nxt_st.file_arm   = 1'b1;
         nxt_st.file_found = 1'b0;
      end else if (st_ff.file_arm) begin
         if (st_ff.file_cnt <= 22'h000001) begin
            nxt_st.file_arm   = 1'b0;
            nxt_st.file_found = 1'b1;
         end else begin
            nxt_st.file_cnt = st_ff.file_cnt - 22'h000001;
         end
      end

      // toggle clears; removal wins over a clear in the same cycle
      ack_edge        = st_ff.ack_s2 ^ st_ff.ack_prev;
      nxt_st.ack_prev = st_ff.ack_s2;
      if (!st_ff.ls_s2) begin
         nxt_st.missing = 1'b1;
      end else if (ack_edge) begin
         nxt_st.missing = 1'b0;
      end
      nxt_st.load = st_ff.rp_s2 | nxt_st.missing | ~st_ff.ls_s2;

      ev[EV_BYTE]  = nxt_st.bit_cnt[3] & ~st_ff.bit_cnt[3];
      ev[EV_RECORD_MARK_DET] = nxt_st.mark_cnt[2] & ~st_ff.mark_cnt[2];
      ev[EV_FILE_MARK_DET] = nxt_st.mark_cnt[3] & ~st_ff.mark_cnt[3];
      ev[EV_FILE]  = nxt_st.file_found & ~st_ff.file_found;
      ev[EV_BEGIN] = mk.clean[0] & ~st_ff.clean_prev[0];
      ev[EV_END]   = mk.clean[1] & ~st_ff.clean_prev[1];
      ev[EV_CART]  = nxt_st.missing & ~st_ff.missing;
      nxt_st.clean_prev = mk.clean;

      // Sticky status, read clears; a new event in that cycle survives
      if (RD && ADDR == ADR_STATUS) begin
         nxt_st.status = ev;
      end else begin
         nxt_st.status = st_ff.status | ev;
      end
      if (WR && ADDR == ADR_MASK) begin
         nxt_st.mask = WDATA[6:0];
      end
      nxt_st.irq = |(nxt_st.status & nxt_st.mask);

      // Read data stand for one cycle only; unmapped reads give zero
      nxt_st.rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            ADR_STATUS: nxt_st.rdata = {1'b0, st_ff.status};
            ADR_MASK:   nxt_st.rdata = {1'b0, st_ff.mask};
            ADR_DATA:   nxt_st.rdata = st_ff.shreg;
            ADR_LEVEL:  nxt_st.rdata = {st_ff.missing, mk.clean, st_ff.file_found,
                                        st_ff.mark_cnt[3], st_ff.mark_cnt[2],
                                        st_ff.bit_cnt[3], st_ff.gap_on};
            default:    nxt_st.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_ff      <= '0;
         st_ff.ls_s1 <= 1'b1;
         st_ff.ls_s2 <= 1'b1;
         st_ff.mask <= MASK_RST;
         st_ff.load <= LOAD_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flip-flops
   assign RDATA             = st_ff.rdata;
   assign IRQ               = st_ff.irq;
   assign CARTRIDGE_MISSING = st_ff.missing;
   assign LOAD_INIT         = st_ff.load;
   assign BEGIN_DET         = mk.clean[0];
   assign END_DET           = mk.clean[1];
   assign RECORD_MARK_DET   = st_ff.mark_cnt[2];
   assign FILE_MARK_DET     = st_ff.mark_cnt[3];
   assign BYTE_READY        = st_ff.bit_cnt[3];
   assign FILE_GAP_FOUND    = st_ff.file_found;
   assign READ_BYTE         = st_ff.shreg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_gap_trig;
      rd_pulse && st_ff.fge_s2;
   endsequence
   sequence s_gap_exp;
      gap_exp;
   endsequence

   a_cart_set: assert property (@(posedge CLK) disable iff (!RST_N)
      !st_ff.ls_s2 |=> CARTRIDGE_MISSING && LOAD_INIT)
      else $error("removal did not set missing flag");
   a_cart_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (CARTRIDGE_MISSING && !ack_edge) |=> CARTRIDGE_MISSING)
      else $error("missing flag cleared without toggle");
   a_load_reset: assert property (@(posedge CLK) disable iff (!RST_N)
      st_ff.rp_s2 |=> LOAD_INIT)
      else $error("load not high on reset pulse");
   a_gap_retrig: assert property (@(posedge CLK) disable iff (!RST_N)
      s_gap_trig |=> st_ff.gap_on && st_ff.gap_cnt == GAP_CYC)
      else $error("gap timer not retriggered");
   a_gap_expiry: assert property (@(posedge CLK) disable iff (!RST_N)
      (s_gap_exp and (st_ff.fge_s2 && !bit_four && !st_ff.mark_cnt[3]))
      |=> st_ff.mark_cnt == $past(st_ff.mark_cnt) + 4'h1)
      else $error("expiry did not count a no-flux period");
   a_mark_clear: assert property (@(posedge CLK) disable iff (!RST_N)
      !st_ff.fge_s2 |=> !RECORD_MARK_DET && !FILE_MARK_DET)
      else $error("mark counter not cleared");
   a_bit_four: assert property (@(posedge CLK) disable iff (!RST_N)
      bit_four |=> st_ff.mark_cnt == 4'h0)
      else $error("bit count four did not clear marks");
   a_bit_reset: assert property (@(posedge CLK) disable iff (!RST_N)
      s_gap_exp |=> st_ff.bit_cnt == 4'h0 && !BYTE_READY)
      else $error("expiry did not reset bit counter");
   a_file_found: assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.file_arm && st_ff.file_cnt == 22'h000001 && st_ff.ffe_s2 && !lsb_tog)
      |=> FILE_GAP_FOUND ##1 IRQ || !st_ff.mask[EV_FILE] || st_ff.status[EV_FILE])
      else $error("file gap not flagged on expiry");
   a_file_off: assert property (@(posedge CLK) disable iff (!RST_N)
      !st_ff.ffe_s2 |=> !FILE_GAP_FOUND && !st_ff.file_arm)
      else $error("file timer active while disabled");
   a_byte_event: assert property (@(posedge CLK) disable iff (!RST_N)
      ev[EV_BYTE] |=> st_ff.status[EV_BYTE] && BYTE_READY)
      else $error("byte end not flagged");
   a_shift_in: assert property (@(posedge CLK) disable iff (!RST_N)
      rd_pulse |=> READ_BYTE[0] == $past(st_ff.rd_s2))
      else $error("read data not shifted in");

   // One counted no-flux period, with no clear pending
   sequence s_mark_step;
      gap_exp && st_ff.fge_s2 && !bit_four;
   endsequence

   // Mark outputs follow the counter; eight drops the record mark again
   a_record_mark_det_four: assert property (@(posedge CLK) disable iff (!RST_N)
      (s_mark_step and (st_ff.mark_cnt == 4'h3)) |=> RECORD_MARK_DET && !FILE_MARK_DET)
      else $error("record mark not raised at four");
   a_file_mark_det_eight: assert property (@(posedge CLK) disable iff (!RST_N)
      (s_mark_step and (st_ff.mark_cnt == 4'h7)) |=> FILE_MARK_DET && !RECORD_MARK_DET)
      else $error("file mark not raised at eight");
   // Eighth counted pulse raises byte ready with its bit shifted in
   a_byte_eight: assert property (@(posedge CLK) disable iff (!RST_N)
      (rd_pulse && !gap_exp && st_ff.bit_cnt == 4'h7 && (st_ff.gap_on || st_ff.fge_s2))
      |=> BYTE_READY && READ_BYTE[0] == $past(st_ff.rd_s2))
      else $error("byte ready not raised at eight");
   // A set latch must keep the tape logic initialised
   a_load_absent: assert property (@(posedge CLK) disable iff (!RST_N)
      CARTRIDGE_MISSING |-> LOAD_INIT)
      else $error("load low while cartridge missing");
   // Clean begin marker rise must reach the status flag
   a_marker_flag: assert property (@(posedge CLK) disable iff (!RST_N)
      (mk.clean[0] && !st_ff.clean_prev[0]) |=> st_ff.status[EV_BEGIN])
      else $error("begin marker flag not set");
endmodule : tape_read_monitor

// ### logic/tape_mon_pkg.sv
// Constants of the tape read monitor: register map, status layout, timing.
// Assumes a 125 MHz system clock; all times are turned into cycle counts here.
package tape_mon_pkg;
   // System clock
   localparam int        CLK_PERIOD_NS  = 8;
   // Marker debounce, a least time: rounded up
   localparam int        DEB_TIME_NS    = 20000;
   localparam int        DEB_W          = 12;
   localparam logic [11:0] DEB_CYCLES   = 12'((DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Gap detector timeout, a longest time: rounded down
   localparam int        GAP_TIME_NS    = 60000;
   localparam int        GAP_W          = 13;
   localparam logic [12:0] GAP_CYCLES   = 13'(GAP_TIME_NS / CLK_PERIOD_NS);
   // File-gap timer, 31.5 ms
   localparam int        FILE_TIME_NS   = 31500000;
   localparam int        FILE_W         = 22;
   localparam logic [21:0] FILE_CYCLES  = 22'(FILE_TIME_NS / CLK_PERIOD_NS);
   // Register byte addresses
   localparam logic [7:0] ADR_STATUS    = 8'h00;
   localparam logic [7:0] ADR_MASK      = 8'h04;
   localparam logic [7:0] ADR_DATA      = 8'h08;
   localparam logic [7:0] ADR_LEVEL     = 8'h0c;
   // Status and mask bit positions
   localparam int        EV_BYTE        = 0;
   localparam int        EV_RECORD_MARK_DET       = 1;
   localparam int        EV_FILE_MARK_DET       = 2;
   localparam int        EV_FILE        = 3;
   localparam int        EV_BEGIN       = 4;
   localparam int        EV_END         = 5;
   localparam int        EV_CART        = 6;
   localparam int        EV_N           = 7;
   // Reset values
   localparam logic [6:0] MASK_RST      = 7'h00;
   localparam logic       LOAD_RST      = 1'b1;
endpackage : tape_mon_pkg

// ### logic/marker_if.sv
// Carrier between the monitor and its marker debouncer.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface marker_if;
   logic [1:0] raw;    // Synchronised markers, bit 0 begin, bit 1 end
   logic [1:0] clean;  // Debounced markers
   modport deb (input raw, output clean);
   modport mon (output raw, input clean);
endinterface : marker_if

// ### logic/marker_debounce.sv
// Two-channel debouncer for the tape begin and end markers.
// Assumes raw inputs are already synchronised to CLK.
`timescale 1ns/10ps
module marker_debounce
   import tape_mon_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   marker_if.deb    m
);
   typedef struct packed {
      logic [1:0][11:0] cnt;
      logic [1:0]       clean;
   } deb_state_t;

   deb_state_t st_ff;
   deb_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // both edges delayed
   // A level must hold a full interval before it passes, so ringing is lost
   always_comb begin
      nxt_st = st_ff;
      for (int i = 0; i < 2; i++) begin
         if (m.raw[i] == st_ff.clean[i]) begin
            nxt_st.cnt[i] = 12'h000;
         end else if (st_ff.cnt[i] == DEB_CYCLES - 12'h001) begin
            nxt_st.clean[i] = m.raw[i];
            nxt_st.cnt[i]   = 12'h000;
         end else begin
            nxt_st.cnt[i] = st_ff.cnt[i] + 12'h001;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign m.clean = st_ff.clean;

   a_deb_begin_pass: assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.cnt[0] == DEB_CYCLES - 12'h001 && m.raw[0] != st_ff.clean[0])
      |=> (st_ff.clean[0] == $past(m.raw[0])))
      else $error("begin marker did not pass after debounce time");
   a_deb_end_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.cnt[1] < DEB_CYCLES - 12'h001) |=> $stable(st_ff.clean[1]))
      else $error("end marker changed before debounce time");
endmodule : marker_debounce

// ### testbench/tape_head_model.sv
// Model of the head read electronics: recovered read clock and data.
// Assumes the bench calls its tasks; the clock idles low between frames.
`timescale 1ns/10ps
module tape_head_model (
   output logic rd_clk,
   output logic rd_data
);
   ////////////////////////////////////////////////////////////
   // Idle line levels before the first frame
   initial begin
      rd_clk  = 1'b0;
      rd_data = 1'b0;
   end
   task automatic pulse(input logic d);
      // One step late, so back-to-back cells never set data twice at once
      #1 rd_data = d;
      #21 rd_clk = 1'b1;
      #32 rd_clk = 1'b0;
      // Released data shows the inverse, never a stale copy
      #10 rd_data = ~d;
   endtask : pulse
   task automatic nibble(input logic [3:0] b);
      for (int i = 3; i >= 0; i--) begin
         pulse(b[i]);
      end
   endtask : nibble
endmodule : tape_head_model

// ### testbench/test_tape_read_monitor.sv
// Self-checking bench of the tape read monitor.
// Assumes shortened gap and file timers; the head model drives the read link.
`timescale 1ns/10ps
module test_tape_read_monitor;
   import tape_mon_pkg::*;
   localparam logic [12:0] GAP = 13'd40;
   localparam logic [21:0] FIL = 22'd200;
   logic       clk, rst_n, sys_rst, load_sw, cart_ack, fge, ffe, beg_m, end_m, wr, rd;
   logic       rd_clk, rd_data, irq, missing, load_init, beg_det, end_det;
   logic       record_mark_det, file_mark_det, byte_rdy, found;
   logic [7:0] addr, wdata, rdata, rbyte;
   int         failures, comparisons, i;
   ////////////////////////////////////////////////////////////
   // Design and far side
   tape_read_monitor #(.GAP_CYC(GAP), .FILE_CYC(FIL)) i_tape_read_monitor (
      .CLK(clk), .RST_N(rst_n), .SYS_RESET_PULSE(sys_rst), .LOAD_SWITCH(load_sw),
      .CART_ACK(cart_ack), .FIND_GAP_ENABLE(fge), .FILE_FIND_ENABLE(ffe),
      .TAPE_RD_CLK(rd_clk), .TAPE_RD_DATA(rd_data), .TAPE_BEGIN_MARKER(beg_m),
      .TAPE_END_MARKER(end_m), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .IRQ(irq), .CARTRIDGE_MISSING(missing), .LOAD_INIT(load_init),
      .BEGIN_DET(beg_det), .END_DET(end_det), .RECORD_MARK_DET(record_mark_det),
      .FILE_MARK_DET(file_mark_det), .BYTE_READY(byte_rdy), .FILE_GAP_FOUND(found),
      .READ_BYTE(rbyte));
   tape_head_model i_tape_head_model (.rd_clk(rd_clk), .rd_data(rd_data));
   // 125 MHz clock
   initial clk = 1'b0;
   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////
   // Compare, bus and wait helpers
   task automatic check_bit(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask : check_bit
   task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : check_byte
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg
   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 check_byte(n, e, rdata);
   endtask : rd_reg
   // Single pulses, each left to expire as one no-flux period
   task automatic no_flux_period(input int n);
      repeat (n) begin
         i_tape_head_model.pulse(1'b1);
         cyc(60);
      end
   endtask : no_flux_period
   task automatic stop_test;
      if (failures == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      failures = 0;
      comparisons = 0;
      {rst_n, sys_rst, cart_ack, fge, ffe, beg_m, end_m, wr, rd} = '0;
      load_sw = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      cyc(6);
      check_bit("load_init", 1'b1, load_init);
      rst_n <= 1'b1;
      cyc(6);
      check_bit("load_init", 1'b0, load_init);
      rd_reg(ADR_MASK, {1'b0, MASK_RST}, "mask");
      wr_reg(ADR_MASK, 8'h7f);
      rd_reg(ADR_MASK, 8'h7f, "mask");
      rd_reg(8'h10, 8'h00, "unmapped");
      // Byte split by a pause shorter than the gap timeout
      fge <= 1'b1;
      cyc(4);
      i_tape_head_model.nibble(4'ha);
      cyc(25);
      i_tape_head_model.nibble(4'h5);
      cyc(4);
      check_bit("byte_ready", 1'b1, byte_rdy);
      check_byte("read_byte", 8'ha5, rbyte);
      check_bit("irq", 1'b1, irq);
      rd_reg(ADR_DATA, 8'ha5, "data");
      cyc(50);
      check_bit("byte_ready", 1'b0, byte_rdy);
      rd_reg(ADR_STATUS, 8'h01, "status");
      cyc(2);
      check_bit("irq", 1'b0, irq);
      // Record then file mark from a cleared counter
      fge <= 1'b0;
      cyc(4);
      fge <= 1'b1;
      cyc(4);
      no_flux_period(3);
      check_bit("record_mark_det", 1'b0, record_mark_det);
      no_flux_period(1);
      check_bit("record_mark_det", 1'b1, record_mark_det);
      no_flux_period(4);
      check_bit("file_mark_det", 1'b1, file_mark_det);
      check_bit("record_mark_det", 1'b0, record_mark_det);
      rd_reg(ADR_STATUS, 8'h06, "status");
      fge <= 1'b0;
      cyc(6);
      check_bit("file_mark_det", 1'b0, file_mark_det);
      // Four bits of a byte wipe the partial mark count
      fge <= 1'b1;
      cyc(4);
      no_flux_period(3);
      i_tape_head_model.nibble(4'h9);
      cyc(60);
      no_flux_period(2);
      check_bit("record_mark_det", 1'b0, record_mark_det);
      no_flux_period(1);
      check_bit("record_mark_det", 1'b1, record_mark_det);
      check_bit("found", 1'b0, found);
      rd_reg(ADR_STATUS, 8'h02, "status");
      // Fast skip: steady pulses, then a long blank
      ffe <= 1'b1;
      cyc(4);
      repeat (4) i_tape_head_model.nibble(4'h3);
      cyc(4);
      check_bit("found", 1'b0, found);
      for (i = 0; i < 400 && found !== 1'b1; i++) cyc(1);
      if (i == 400) begin
         failures++;
         stop_test();
      end
      check_bit("irq", 1'b1, irq);
      rd_reg(ADR_STATUS, 8'h09, "status");
      ffe <= 1'b0;
      cyc(6);
      check_bit("found", 1'b0, found);
      // Markers with only the cartridge event unmasked
      // marker flags only reported, never used to stop the tape
      wr_reg(ADR_MASK, 8'h40);
      beg_m <= 1'b1;
      end_m <= 1'b1;
      cyc(2000);
      check_bit("begin_det", 1'b0, beg_det);
      for (i = 0; i < 1000 && beg_det !== 1'b1; i++) cyc(1);
      if (i == 1000) begin
         failures++;
         stop_test();
      end
      check_bit("end_det", 1'b1, end_det);
      check_bit("irq", 1'b0, irq);
      rd_reg(ADR_LEVEL, 8'h60, "level");
      wr_reg(ADR_MASK, 8'h10);
      cyc(3);
      check_bit("irq", 1'b1, irq);
      rd_reg(ADR_STATUS, 8'h30, "status");
      beg_m <= 1'b0;
      end_m <= 1'b0;
      cyc(2000);
      check_bit("begin_det", 1'b1, beg_det);
      cyc(700);
      check_bit("end_det", 1'b0, end_det);
      // Cartridge removal latch and load line
      wr_reg(ADR_MASK, 8'h7f);
      load_sw <= 1'b0;
      cyc(6);
      check_bit("missing", 1'b1, missing);
      check_bit("load_init", 1'b1, load_init);
      load_sw <= 1'b1;
      cyc(6);
      check_bit("missing", 1'b1, missing);
      cart_ack <= 1'b1;
      cyc(6);
      check_bit("missing", 1'b0, missing);
      check_bit("load_init", 1'b0, load_init);
      rd_reg(ADR_STATUS, 8'h40, "status");
      sys_rst <= 1'b1;
      cyc(6);
      check_bit("load_init", 1'b1, load_init);
      sys_rst <= 1'b0;
      cyc(6);
      check_bit("load_init", 1'b0, load_init);
      stop_test();
   end
endmodule : test_tape_read_monitor
